// File: sim/tam_monitor_asserts.sv
// port-level assertions for the thermal monitor
`timescale 1ns/10ps
`default_nettype none
`include "tam_defs.vh"
module tam_monitor_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] temp_rect,
  input wire logic [15:0] temp_inv,
  input wire logic [15:0] temp_cav,
  input wire logic comp_start,
  input wire logic comp_stop,
  input wire logic speed_reduce,
  input wire logic shutdown_cmd,
  input wire logic irq
);
  logic acc;
  logic go;
  logic cold;
  logic hot;
  logic lim_ok;
  logic mask_seen_q;
  assign acc = psel && penable;
  assign go = comp_start || (acc && pwrite && pwdata[0] &&
    paddr == {`TAM_IX_CTRL, 2'b00});
  // limit figures are the reset values; the bench never rewrites them
  assign cold = temp_inv <= 16'h0032 && temp_cav <= 16'h0032 &&
    temp_rect <= 16'h0032;
  assign hot = temp_inv > 16'h0037 || temp_cav > 16'h0037;
  assign lim_ok = temp_inv < 16'h0041 && temp_cav < 16'h004b &&
    temp_rect < 16'h0041;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_seen_q <= 1'b0;
    else if (acc && pwrite && paddr == {`TAM_IX_MASK, 2'b00})
      mask_seen_q <= 1'b1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_always_a: assert property (pready)
    else $error("pready low");
  err_access_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  misalign_err_a: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  unmapped_err_a: assert property (acc && paddr == 18'h00000 |-> pslverr)
    else $error("unmapped access not refused");
  rdata_upper_a: assert property (prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  fault_hold_a: assert property (shutdown_cmd && !go |=> shutdown_cmd)
    else $error("shutdown released without a start");
  quiet_temps_a: assert property (cold [*3] |-> !speed_reduce)
    else $error("speed reduction with all temperatures low");
  cool_delay_a: assert property ($rose(speed_reduce) && lim_ok |->
    $past(hot, 56))
    else $error("cooling alarm too early");
  irq_masked_a: assert property (!mask_seen_q |-> !irq)
    else $error("interrupt while all sources masked");
endmodule
`default_nettype wire

// File: sim/tam_plant.sv
// temperature sensors and motor drive around the thermal monitor
`timescale 1ns/10ps
`default_nettype none
module tam_plant (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] set_rect,
  input wire logic [15:0] set_inv,
  input wire logic [15:0] set_cav,
  input wire logic start_req,
  input wire logic shutdown_cmd,
  output logic [15:0] temp_rect,
  output logic [15:0] temp_inv,
  output logic [15:0] temp_cav,
  output logic comp_start,
  output logic comp_stop
);
  logic shut_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      temp_rect <= 16'h0019;
      temp_inv <= 16'h0019;
      temp_cav <= 16'h0019;
      comp_start <= 1'b0;
      comp_stop <= 1'b0;
      shut_q <= 1'b0;
    end
    else
    begin
      // sensors are sampled once a clock, like a real converter
      temp_rect <= set_rect;
      temp_inv <= set_inv;
      temp_cav <= set_cav;
      comp_start <= start_req;
      // the drive trips once on each new shutdown order
      comp_stop <= shutdown_cmd && !shut_q;
      shut_q <= shutdown_cmd;
    end
  end
endmodule
`default_nettype wire

// File: sim/thermal_alarm_fault_monitor_tb_top.sv
// self-checking bench for the thermal monitor
`timescale 1ns/10ps
`default_nettype none
`include "tam_defs.vh"
module thermal_alarm_fault_monitor_tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [15:0] temp_rect;
  wire [15:0] temp_inv;
  wire [15:0] temp_cav;
  wire comp_start;
  wire comp_stop;
  wire speed_reduce;
  wire shutdown_cmd;
  wire irq;
  logic [15:0] set_rect;
  logic [15:0] set_inv;
  logic [15:0] set_cav;
  logic start_req;
  logic [31:0] rd;
  logic err;
  int fail_count;
  int compares;
  logic [31:0] rows [0:16];
  tam_monitor #(.TICK_CYCLES(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .temp_rect(temp_rect),
    .temp_inv(temp_inv), .temp_cav(temp_cav), .comp_start(comp_start),
    .comp_stop(comp_stop), .speed_reduce(speed_reduce),
    .shutdown_cmd(shutdown_cmd), .irq(irq));
  tam_plant plant_u (
    .pclk(pclk), .presetn(presetn), .set_rect(set_rect), .set_inv(set_inv),
    .set_cav(set_cav), .start_req(start_req), .shutdown_cmd(shutdown_cmd),
    .temp_rect(temp_rect), .temp_inv(temp_inv), .temp_cav(temp_cav),
    .comp_start(comp_start), .comp_stop(comp_stop));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic sw(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [17:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      fail_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] ix, input logic [31:0] d);
    apb(1'b1, {ix, 2'b00}, d);
  endtask
  task automatic rdc(input logic [15:0] ix, input logic [31:0] exp);
    apb(1'b0, {ix, 2'b00}, 32'h0);
    chk(rd, exp);
  endtask
  // waits for speed_reduce (sel 0) or shutdown_cmd (sel 1)
  task automatic wsig(input bit sel, input int max);
    int n;
    n = 0;
    while ((sel ? shutdown_cmd : speed_reduce) !== 1'b1 && n < max)
    begin
      sw(1);
      n++;
    end
    compares++;
    if ((sel ? shutdown_cmd : speed_reduce) !== 1'b1)
    begin
      fail_count++;
      finish_test();
    end
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    set_rect = 16'h0019;
    set_inv = 16'h0019;
    set_cav = 16'h0019;
    start_req = 1'b0;
    fail_count = 0;
    compares = 0;
    rows = '{{`TAM_IX_INV_OPER_ALM, `TAM_RST_INV_OPER_ALM},
      {`TAM_IX_CAV_OPER_ALM, `TAM_RST_CAV_OPER_ALM},
      {`TAM_IX_INV_OPER_FLT, `TAM_RST_INV_OPER_FLT},
      {`TAM_IX_CAV_OPER_FLT, `TAM_RST_CAV_OPER_FLT},
      {`TAM_IX_CAV_COOL_LIM, `TAM_RST_COOL_LIM},
      {`TAM_IX_INV_DLY_CFG, `TAM_RST_DLY_CFG},
      {`TAM_IX_INV_TRIG, `TAM_RST_TRIG},
      {`TAM_IX_INV_MON_CFG, `TAM_RST_MON_CFG},
      {`TAM_IX_REC_STUP_TMR, `TAM_RST_STUP_TMR},
      {`TAM_IX_REC_STUP_FLT, `TAM_RST_REC_STUP_FLT},
      {`TAM_IX_REC_STUP_ALM, `TAM_RST_REC_STUP_ALM},
      {`TAM_IX_CAV_STUP_FLT, `TAM_RST_CAV_STUP_FLT},
      {`TAM_IX_CAV_STUP_ALM, `TAM_RST_CAV_STUP_ALM},
      {`TAM_IX_REC_OPER_ALM, `TAM_RST_REC_OPER_ALM},
      {`TAM_IX_REC_OPER_FLT, `TAM_RST_REC_OPER_FLT},
      {`TAM_IX_INV_STUP_REM, 16'h0000}, {`TAM_IX_MASK, 16'h0000}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    sw(1);
    chk({29'h0, speed_reduce, shutdown_cmd, irq}, 32'h0);
    foreach (rows[i])
      rdc(rows[i][31:16], {16'h0, rows[i][15:0]});
    apb(1'b0, 18'h00000, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, {`TAM_IX_INV_OPER_ALM, 2'b01}, 32'h0);
    chk({31'h0, err}, 32'h1);
    // one-minute timers keep the run short
    wr(`TAM_IX_REC_STUP_TMR, 32'h1);
    wr(`TAM_IX_INV_STUP_TMR, 32'h1);
    wr(`TAM_IX_CAV_STUP_TMR, 32'h1);
    wr(`TAM_IX_INV_MON_CFG, 32'h1);
    wr(`TAM_IX_CAV_MON_CFG, 32'h1);
    wr(`TAM_IX_MASK, 32'h108);
    rdc(`TAM_IX_INV_STUP_TMR, 32'h1);
    wr(`TAM_IX_CTRL, 32'h1);
    set_inv <= 16'h0044;
    sw(20);
    chk({31'h0, speed_reduce}, 32'h0);
    rdc(`TAM_IX_INV_STUP_REM, 32'h1);
    rdc(`TAM_IX_INV_MON_REM, 32'h1);
    sw(260);
    chk({31'h0, speed_reduce}, 32'h1);
    rdc(`TAM_IX_INV_STUP_REM, 32'h0);
    set_inv <= 16'h0019;
    set_rect <= 16'h003c;
    sw(120);
    chk({31'h0, speed_reduce}, 32'h0);
    set_rect <= 16'h0046;
    sw(3);
    chk({30'h0, shutdown_cmd, irq}, 32'h3);
    apb(1'b0, {`TAM_IX_STATUS, 2'b00}, 32'h0);
    chk(rd & 32'h8, 32'h8);
    set_rect <= 16'h0019;
    wr(`TAM_IX_STATUS, 32'h3ff);
    sw(2);
    chk({30'h0, shutdown_cmd, irq}, 32'h2);
    @(posedge pclk);
    start_req <= 1'b1;
    @(posedge pclk);
    start_req <= 1'b0;
    sw(3);
    chk({31'h0, shutdown_cmd}, 32'h0);
    sw(260);
    set_inv <= 16'h0038;
    sw(40);
    chk({31'h0, speed_reduce}, 32'h0);
    set_inv <= 16'h0032;
    sw(80);
    chk({31'h0, speed_reduce}, 32'h0);
    set_inv <= 16'h0038;
    sw(50);
    chk({31'h0, speed_reduce}, 32'h0);
    wsig(1'b0, 30);
    rdc(`TAM_IX_INV_DLY_REM, 32'he);
    sw(3400);
    chk({31'h0, shutdown_cmd}, 32'h0);
    wsig(1'b1, 300);
    apb(1'b0, {`TAM_IX_STATUS, 2'b00}, 32'h0);
    chk(rd & 32'h100, 32'h100);
    chk({31'h0, irq}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    sw(1);
    chk({29'h0, speed_reduce, shutdown_cmd, irq}, 32'h0);
    rdc(`TAM_IX_INV_STUP_TMR, {16'h0, `TAM_RST_STUP_TMR});
    rdc(`TAM_IX_STATUS, 32'h0);
    finish_test();
  end
endmodule
bind tam_monitor tam_monitor_asserts chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .temp_rect(temp_rect),
  .temp_inv(temp_inv), .temp_cav(temp_cav), .comp_start(comp_start),
  .comp_stop(comp_stop), .speed_reduce(speed_reduce),
  .shutdown_cmd(shutdown_cmd), .irq(irq));
`default_nettype wire

// File: src/tam_cool_unit.v
// cooling-control supervision of one temperature: start delay and fault delay
`timescale 1ns/10ps
`default_nettype none
module tam_cool_unit (
  input wire clk,
  input wire rst_n,
  input wire sec_tick,
  input wire min_tick,
  input wire start,
  input wire run,
  input wire over,
  input wire [15:0] dly_cfg,
  input wire [15:0] trig_cfg,
  input wire [15:0] mon_cfg,
  output wire [15:0] dly_rem,
  output wire [15:0] mon_rem,
  output wire alarm,
  output wire fault
);
`include "tam_defs.vh"
reg [15:0] mon_q;
reg [15:0] min_q;
reg [5:0] sec_q;
reg cnt_q;
reg fault_q;
wire active;
wire expired;
wire trig_hit;

assign active = run && (mon_q == 16'h0000); // RL4
assign expired = (min_q == 16'h0000) && (sec_q == 6'd0);
// remaining time at or below the trigger setting {minutes, seconds}
assign trig_hit = (min_q < {8'h00, trig_cfg[15:8]}) ||
                  ((min_q == {8'h00, trig_cfg[15:8]}) &&
                   ({2'b00, sec_q} <= trig_cfg[7:0]));
assign alarm = (cnt_q && trig_hit) || fault_q; // RL6
assign fault = fault_q;
assign dly_rem = cnt_q ? min_q : 16'h0000; // RL13 RL15
assign mon_rem = mon_q;

// ----------------------------------------
// start delay, minutes
// ----------------------------------------
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
    mon_q <= 16'h0000;
  else if (start)
    mon_q <= mon_cfg;
  else if (min_tick && (mon_q != 16'h0000))
    mon_q <= mon_q - 16'h0001; // RL15
end

// ----------------------------------------
// fault delay, one-second resolution
// ----------------------------------------
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    min_q <= 16'h0000;
    sec_q <= 6'd0;
    cnt_q <= 1'b0;
    fault_q <= 1'b0;
  end
  else if (start || !active)
  begin
    cnt_q <= 1'b0;
    if (start)
      fault_q <= 1'b0;
  end
  else if (!over)
    cnt_q <= 1'b0; // RL9
  else if (!cnt_q)
  begin
    // full reload on every new crossing
    cnt_q <= 1'b1; // RL5 RL10
    min_q <= dly_cfg;
    sec_q <= 6'd0;
  end
  else if (expired)
    fault_q <= 1'b1; // RL8
  else if (sec_tick)
  begin
    if (sec_q == 6'd0)
    begin
      min_q <= min_q - 16'h0001; // RL16
      sec_q <= `TAM_SEC_LAST;
    end
    else
      sec_q <= sec_q - 6'd1;
  end
end
endmodule
`default_nettype wire

// File: src/tam_defs.vh
// register indices, reset values and timing constants of the thermal monitor
`ifndef TAM_DEFS_VH
`define TAM_DEFS_VH
// register indices; byte address is four times the index
`define TAM_IX_INV_OPER_ALM 16'h9d20
`define TAM_IX_CAV_OPER_ALM 16'h9d23
`define TAM_IX_INV_OPER_FLT 16'h9d32
`define TAM_IX_CAV_OPER_FLT 16'h9d35
`define TAM_IX_CAV_COOL_LIM 16'h9d99
`define TAM_IX_CAV_DLY_CFG 16'h9d9a
`define TAM_IX_CAV_DLY_REM 16'h9d9b
`define TAM_IX_CAV_TRIG 16'h9d9c
`define TAM_IX_CAV_MON_CFG 16'h9d9d
`define TAM_IX_CAV_MON_REM 16'h9d9e
`define TAM_IX_INV_COOL_LIM 16'h9d9f
`define TAM_IX_INV_DLY_CFG 16'h9da0
`define TAM_IX_INV_DLY_REM 16'h9da1
`define TAM_IX_INV_TRIG 16'h9da2
`define TAM_IX_INV_MON_CFG 16'h9da3
`define TAM_IX_INV_MON_REM 16'h9da4
`define TAM_IX_REC_STUP_TMR 16'h9df0
`define TAM_IX_REC_STUP_REM 16'h9df1
`define TAM_IX_REC_STUP_FLT 16'h9df2
`define TAM_IX_REC_STUP_ALM 16'h9df3
`define TAM_IX_INV_STUP_TMR 16'h9df4
`define TAM_IX_INV_STUP_REM 16'h9df5
`define TAM_IX_INV_STUP_FLT 16'h9df6
`define TAM_IX_INV_STUP_ALM 16'h9df7
`define TAM_IX_CAV_STUP_TMR 16'h9df8
`define TAM_IX_CAV_STUP_REM 16'h9df9
`define TAM_IX_CAV_STUP_FLT 16'h9dfa
`define TAM_IX_CAV_STUP_ALM 16'h9dfb
`define TAM_IX_REC_OPER_ALM 16'ha439
`define TAM_IX_REC_OPER_FLT 16'ha43a
`define TAM_IX_CTRL 16'h9e00
`define TAM_IX_STATUS 16'h9e01
`define TAM_IX_MASK 16'h9e02
`define TAM_IX_STATE 16'h9e03
// reset values, degrees C or minutes, trigger as {minutes, seconds}
`define TAM_RST_INV_OPER_ALM 16'h0041
`define TAM_RST_CAV_OPER_ALM 16'h004b
`define TAM_RST_INV_OPER_FLT 16'h0046
`define TAM_RST_CAV_OPER_FLT 16'h0050
`define TAM_RST_COOL_LIM 16'h0037
`define TAM_RST_DLY_CFG 16'h000f
`define TAM_RST_TRIG 16'h0e2d
`define TAM_RST_MON_CFG 16'h00b4
`define TAM_RST_STUP_TMR 16'h000f
`define TAM_RST_REC_STUP_FLT 16'h004b
`define TAM_RST_REC_STUP_ALM 16'h0046
`define TAM_RST_INV_STUP_FLT 16'h004b
`define TAM_RST_INV_STUP_ALM 16'h0046
`define TAM_RST_CAV_STUP_FLT 16'h0055
`define TAM_RST_CAV_STUP_ALM 16'h0050
`define TAM_RST_REC_OPER_ALM 16'h0041
`define TAM_RST_REC_OPER_FLT 16'h0046
// control and status bit positions
`define TAM_CTRL_START 0
`define TAM_CTRL_STOP 1
`define TAM_ST_ALM 0
`define TAM_ST_FLT 3
`define TAM_ST_CALM 6
`define TAM_ST_CFLT 8
`define TAM_ST_W 10
// timing
`define TAM_CLK_HZ 25000000
`define TAM_TICK_S 1
`define TAM_SEC_PER_MIN 6'd60
`define TAM_SEC_LAST 6'd59
`endif

// File: src/tam_monitor.v
// thermal alarm and fault monitor with APB register access
// ----------------------------------------
// How it works
// RL1 - startup limits while the startup timer runs, operational limits after
// RL2 - above alarm limit raises that alarm and requests speed reduction
// RL3 - at or above fault limit raises that fault and commands shutdown
// RL4 - cooling supervision starts after the start delay, default 180 min
// RL5 - above cooling limit starts the fault-delay timer, default 55 C
// RL6 - cooling alarm 15 s after crossing; trigger default 14 min 45 s
// RL7 - cooling alarm requests reduced motor speed
// RL8 - excess for the whole delay, default 15 min, raises cooling fault
// RL9 - dropping below the cooling limit resets the fault-delay timer
// RL10 - a new crossing restarts the timer from its full value
// RL11 - startup limit defaults and 15-minute startup timers with remaining
// RL12 - operational limit defaults per sensor
// RL13 - inverter and cavity expose cooling config and remaining values
// RL14 - rectifier has no cooling supervision
// RL15 - remaining values count down per minute and read zero after expiry
// RL16 - fault-delay timer advances on a one-second tick
// ----------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "tam_defs.vh"
module tam_monitor #(
  parameter TICK_CYCLES = `TAM_CLK_HZ * `TAM_TICK_S
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [15:0] temp_rect,
  input wire [15:0] temp_inv,
  input wire [15:0] temp_cav,
  input wire comp_start,
  input wire comp_stop,
  output wire speed_reduce,
  output wire shutdown_cmd,
  output wire irq
);
localparam NCFG = 23;
localparam S_INV_OA = 5'd0;
localparam S_CAV_OA = 5'd1;
localparam S_INV_OF = 5'd2;
localparam S_CAV_OF = 5'd3;
localparam S_CAV_CL = 5'd4;
localparam S_CAV_DC = 5'd5;
localparam S_CAV_TR = 5'd6;
localparam S_CAV_MC = 5'd7;
localparam S_INV_CL = 5'd8;
localparam S_INV_DC = 5'd9;
localparam S_INV_TR = 5'd10;
localparam S_INV_MC = 5'd11;
localparam S_REC_ST = 5'd12;
localparam S_REC_SF = 5'd13;
localparam S_REC_SA = 5'd14;
localparam S_INV_ST = 5'd15;
localparam S_INV_SF = 5'd16;
localparam S_INV_SA = 5'd17;
localparam S_CAV_ST = 5'd18;
localparam S_CAV_SF = 5'd19;
localparam S_CAV_SA = 5'd20;
localparam S_REC_OA = 5'd21;
localparam S_REC_OF = 5'd22;
localparam S_NONE = 5'd31;

// ----------------------------------------
// decode and defaults
// ----------------------------------------
function [4:0] slot_of;
  input [15:0] ix;
  begin
    case (ix)
      `TAM_IX_INV_OPER_ALM: slot_of = S_INV_OA;
      `TAM_IX_CAV_OPER_ALM: slot_of = S_CAV_OA;
      `TAM_IX_INV_OPER_FLT: slot_of = S_INV_OF;
      `TAM_IX_CAV_OPER_FLT: slot_of = S_CAV_OF;
      `TAM_IX_CAV_COOL_LIM: slot_of = S_CAV_CL;
      `TAM_IX_CAV_DLY_CFG: slot_of = S_CAV_DC;
      `TAM_IX_CAV_TRIG: slot_of = S_CAV_TR;
      `TAM_IX_CAV_MON_CFG: slot_of = S_CAV_MC;
      `TAM_IX_INV_COOL_LIM: slot_of = S_INV_CL;
      `TAM_IX_INV_DLY_CFG: slot_of = S_INV_DC;
      `TAM_IX_INV_TRIG: slot_of = S_INV_TR;
      `TAM_IX_INV_MON_CFG: slot_of = S_INV_MC;
      `TAM_IX_REC_STUP_TMR: slot_of = S_REC_ST;
      `TAM_IX_REC_STUP_FLT: slot_of = S_REC_SF;
      `TAM_IX_REC_STUP_ALM: slot_of = S_REC_SA;
      `TAM_IX_INV_STUP_TMR: slot_of = S_INV_ST;
      `TAM_IX_INV_STUP_FLT: slot_of = S_INV_SF;
      `TAM_IX_INV_STUP_ALM: slot_of = S_INV_SA;
      `TAM_IX_CAV_STUP_TMR: slot_of = S_CAV_ST;
      `TAM_IX_CAV_STUP_FLT: slot_of = S_CAV_SF;
      `TAM_IX_CAV_STUP_ALM: slot_of = S_CAV_SA;
      `TAM_IX_REC_OPER_ALM: slot_of = S_REC_OA;
      `TAM_IX_REC_OPER_FLT: slot_of = S_REC_OF;
      default: slot_of = S_NONE;
    endcase
  end
endfunction

function [15:0] rst_of;
  input [4:0] s;
  begin
    case (s)
      S_INV_OA: rst_of = `TAM_RST_INV_OPER_ALM; // RL12
      S_CAV_OA: rst_of = `TAM_RST_CAV_OPER_ALM;
      S_INV_OF: rst_of = `TAM_RST_INV_OPER_FLT;
      S_CAV_OF: rst_of = `TAM_RST_CAV_OPER_FLT;
      S_REC_OA: rst_of = `TAM_RST_REC_OPER_ALM;
      S_REC_OF: rst_of = `TAM_RST_REC_OPER_FLT;
      S_CAV_CL, S_INV_CL: rst_of = `TAM_RST_COOL_LIM; // RL5
      S_CAV_DC, S_INV_DC: rst_of = `TAM_RST_DLY_CFG; // RL8
      S_CAV_TR, S_INV_TR: rst_of = `TAM_RST_TRIG; // RL6
      S_CAV_MC, S_INV_MC: rst_of = `TAM_RST_MON_CFG; // RL4
      S_REC_ST, S_INV_ST, S_CAV_ST: rst_of = `TAM_RST_STUP_TMR; // RL11
      S_REC_SF: rst_of = `TAM_RST_REC_STUP_FLT;
      S_REC_SA: rst_of = `TAM_RST_REC_STUP_ALM;
      S_INV_SF: rst_of = `TAM_RST_INV_STUP_FLT;
      S_INV_SA: rst_of = `TAM_RST_INV_STUP_ALM;
      S_CAV_SF: rst_of = `TAM_RST_CAV_STUP_FLT;
      S_CAV_SA: rst_of = `TAM_RST_CAV_STUP_ALM;
      default: rst_of = 16'h0000;
    endcase
  end
endfunction

function [15:0] dec_min;
  input [15:0] v;
  begin
    dec_min = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  end
endfunction

// ----------------------------------------
// apb slave
// ----------------------------------------
reg [15:0] cfg_q [0:NCFG-1];
reg [31:0] rdata_q;
reg [`TAM_ST_W-1:0] stat_q;
reg [`TAM_ST_W-1:0] mask_q;
wire [15:0] ix;
wire [4:0] slot;
wire wr_acc;
wire known;
integer i;
integer j;

assign ix = paddr[17:2];
assign slot = slot_of(ix);
assign pready = 1'b1;
assign wr_acc = psel && penable && pwrite;
assign known = (slot != S_NONE) || (ix == `TAM_IX_CAV_DLY_REM) ||
               (ix == `TAM_IX_CAV_MON_REM) || (ix == `TAM_IX_INV_DLY_REM) ||
               (ix == `TAM_IX_INV_MON_REM) || (ix == `TAM_IX_REC_STUP_REM) ||
               (ix == `TAM_IX_INV_STUP_REM) || (ix == `TAM_IX_CAV_STUP_REM) ||
               (ix == `TAM_IX_CTRL) || (ix == `TAM_IX_STATUS) ||
               (ix == `TAM_IX_MASK) || (ix == `TAM_IX_STATE);
// unmapped or misaligned accesses are flagged, nothing changes
assign pslverr = psel && penable && (!known || (paddr[1:0] != 2'b00));
assign prdata = rdata_q;

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    for (i = 0; i < NCFG; i = i + 1)
      cfg_q[i] <= rst_of(i[4:0]);
  end
  else if (wr_acc && !pslverr && (slot != S_NONE))
    cfg_q[slot] <= pwdata[15:0];
end

// ----------------------------------------
// compressor run state and timebase
// ----------------------------------------
reg run_q;
reg [31:0] div_q;
reg [5:0] secs_q;
reg [15:0] stup_q [0:2];
wire start;
wire stop;
wire sec_tick;
wire min_tick;
wire [31:0] tick_last;

assign tick_last = TICK_CYCLES - 1;
assign start = comp_start || (wr_acc && !pslverr && (ix == `TAM_IX_CTRL) &&
               pwdata[`TAM_CTRL_START]);
assign stop = !start && (comp_stop || (wr_acc && !pslverr &&
              (ix == `TAM_IX_CTRL) && pwdata[`TAM_CTRL_STOP]));
assign sec_tick = run_q && (div_q == tick_last);
assign min_tick = sec_tick && (secs_q == `TAM_SEC_LAST);

// timebase restarts at compressor start so minutes align with it
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    run_q <= 1'b0;
    div_q <= 32'h0000_0000;
    secs_q <= 6'd0;
  end
  else
  begin
    if (start)
      run_q <= 1'b1;
    else if (stop)
      run_q <= 1'b0;
    if (start || !run_q || sec_tick)
      div_q <= 32'h0000_0000;
    else
      div_q <= div_q + 32'h0000_0001;
    if (start || !run_q || min_tick)
      secs_q <= 6'd0;
    else if (sec_tick)
      secs_q <= secs_q + 6'd1;
  end
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    for (j = 0; j < 3; j = j + 1)
      stup_q[j] <= 16'h0000;
  end
  else if (start)
  begin
    stup_q[0] <= cfg_q[S_REC_ST]; // RL11
    stup_q[1] <= cfg_q[S_INV_ST];
    stup_q[2] <= cfg_q[S_CAV_ST];
  end
  else if (min_tick)
  begin
    for (j = 0; j < 3; j = j + 1)
      stup_q[j] <= dec_min(stup_q[j]); // RL15
  end
end

// ----------------------------------------
// limit checks, index 0 rectifier, 1 inverter, 2 cavity
// ----------------------------------------
wire [15:0] temp [0:2];
wire [15:0] alm_lim [0:2];
wire [15:0] flt_lim [0:2];
wire [2:0] in_stup;
wire [2:0] alm;
wire [2:0] flt;
wire [1:0] c_alm;
wire [1:0] c_flt;
wire [15:0] inv_dly_rem;
wire [15:0] inv_mon_rem;
wire [15:0] cav_dly_rem;
wire [15:0] cav_mon_rem;

assign temp[0] = temp_rect;
assign temp[1] = temp_inv;
assign temp[2] = temp_cav;
assign in_stup[0] = stup_q[0] != 16'h0000;
assign in_stup[1] = stup_q[1] != 16'h0000;
assign in_stup[2] = stup_q[2] != 16'h0000;
assign alm_lim[0] = in_stup[0] ? cfg_q[S_REC_SA] : cfg_q[S_REC_OA]; // RL1
assign alm_lim[1] = in_stup[1] ? cfg_q[S_INV_SA] : cfg_q[S_INV_OA]; // RL1
assign alm_lim[2] = in_stup[2] ? cfg_q[S_CAV_SA] : cfg_q[S_CAV_OA]; // RL1
assign flt_lim[0] = in_stup[0] ? cfg_q[S_REC_SF] : cfg_q[S_REC_OF]; // RL1
assign flt_lim[1] = in_stup[1] ? cfg_q[S_INV_SF] : cfg_q[S_INV_OF]; // RL1
assign flt_lim[2] = in_stup[2] ? cfg_q[S_CAV_SF] : cfg_q[S_CAV_OF]; // RL1

genvar g;
generate
  for (g = 0; g < 3; g = g + 1)
  begin : chk
    assign alm[g] = run_q && (temp[g] > alm_lim[g]); // RL2
    assign flt[g] = run_q && (temp[g] >= flt_lim[g]); // RL3
  end
endgenerate

// rectifier is deliberately left without a cooling unit
tam_cool_unit u_inv ( // RL14
  .clk(pclk),
  .rst_n(presetn),
  .sec_tick(sec_tick),
  .min_tick(min_tick),
  .start(start),
  .run(run_q),
  .over(temp_inv > cfg_q[S_INV_CL]),
  .dly_cfg(cfg_q[S_INV_DC]),
  .trig_cfg(cfg_q[S_INV_TR]),
  .mon_cfg(cfg_q[S_INV_MC]),
  .dly_rem(inv_dly_rem),
  .mon_rem(inv_mon_rem),
  .alarm(c_alm[0]),
  .fault(c_flt[0])
);

tam_cool_unit u_cav (
  .clk(pclk),
  .rst_n(presetn),
  .sec_tick(sec_tick),
  .min_tick(min_tick),
  .start(start),
  .run(run_q),
  .over(temp_cav > cfg_q[S_CAV_CL]),
  .dly_cfg(cfg_q[S_CAV_DC]),
  .trig_cfg(cfg_q[S_CAV_TR]),
  .mon_cfg(cfg_q[S_CAV_MC]),
  .dly_rem(cav_dly_rem),
  .mon_rem(cav_mon_rem),
  .alarm(c_alm[1]),
  .fault(c_flt[1])
);

// ----------------------------------------
// fault latch, outputs and interrupt
// ----------------------------------------
reg [2:0] flt_hold_q;
reg [`TAM_ST_W-1:0] lvl_q;
wire [`TAM_ST_W-1:0] lvl;
wire [`TAM_ST_W-1:0] ev;
wire [`TAM_ST_W-1:0] w1c;

assign lvl = {c_flt, c_alm, flt, alm};
assign ev = lvl & ~lvl_q;
assign w1c = (wr_acc && !pslverr && (ix == `TAM_IX_STATUS)) ?
             pwdata[`TAM_ST_W-1:0] : {`TAM_ST_W{1'b0}};
assign speed_reduce = run_q && ((|alm) || (|c_alm)); // RL2 RL7
// a trip holds shutdown until the next start
assign shutdown_cmd = (|flt_hold_q) || (|c_flt); // RL3
assign irq = |(stat_q & mask_q);

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    flt_hold_q <= 3'b000;
    lvl_q <= {`TAM_ST_W{1'b0}};
    stat_q <= {`TAM_ST_W{1'b0}};
    mask_q <= {`TAM_ST_W{1'b0}};
  end
  else
  begin
    flt_hold_q <= start ? 3'b000 : (flt_hold_q | flt); // RL3
    lvl_q <= lvl;
    // a new event outranks a same-cycle clear
    stat_q <= (stat_q & ~w1c) | ev;
    if (wr_acc && !pslverr && (ix == `TAM_IX_MASK))
      mask_q <= pwdata[`TAM_ST_W-1:0];
  end
end

// ----------------------------------------
// read data, captured in the setup cycle
// ----------------------------------------
reg [15:0] rd_mux;
always @*
begin
  rd_mux = 16'h0000;
  if (slot != S_NONE)
    rd_mux = cfg_q[slot];
  else
  begin
    case (ix)
      `TAM_IX_INV_DLY_REM: rd_mux = inv_dly_rem; // RL13
      `TAM_IX_INV_MON_REM: rd_mux = inv_mon_rem;
      `TAM_IX_CAV_DLY_REM: rd_mux = cav_dly_rem;
      `TAM_IX_CAV_MON_REM: rd_mux = cav_mon_rem;
      `TAM_IX_REC_STUP_REM: rd_mux = stup_q[0]; // RL11
      `TAM_IX_INV_STUP_REM: rd_mux = stup_q[1];
      `TAM_IX_CAV_STUP_REM: rd_mux = stup_q[2];
      `TAM_IX_STATUS: rd_mux = {6'h00, stat_q};
      `TAM_IX_MASK: rd_mux = {6'h00, mask_q};
      `TAM_IX_STATE: rd_mux = {1'b0, run_q, shutdown_cmd, speed_reduce,
                               2'b00, lvl};
      default: rd_mux = 16'h0000;
    endcase
  end
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    rdata_q <= 32'h0000_0000;
  else if (psel && !penable && !pwrite)
    rdata_q <= {16'h0000, rd_mux};
end
endmodule
`default_nettype wire
